// file: rtl/ttb_pkg.sv
// constants for the tick timer and buzzer square-wave block
package ttb_pkg;
  localparam int CLK_HZ     = 50_000_000;
  localparam int TMR_CLK_HZ = 1000;
  localparam int BUZ_CLK_HZ = 6000;
  localparam int TICK_MS    = 100;
  localparam int TICK_KHZ   = TICK_MS * TMR_CLK_HZ / 1000;
  localparam int SEC_TICKS  = 10;
  localparam int DIV_1K     = CLK_HZ / TMR_CLK_HZ;
  localparam int DIV_6K     = CLK_HZ / BUZ_CLK_HZ;
  localparam int NCD        = 5;
  localparam int CD_W       = 16;
  localparam int ST_W       = NCD + 1;
  localparam int ST_TICK    = 0;
  localparam int ST_CD0     = 1;
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_BUZ   = 1;
  localparam int CD_TIMEOUT = 0;
  localparam int CD_ADC     = 1;
  localparam int CD_ALARM   = 2;
  localparam int CD_SLEEP   = 3;
  localparam int CD_BLINK   = 4;
  localparam logic [7:0]  ADR_CTRL = 8'h00;
  localparam logic [7:0]  ADR_STAT = 8'h04;
  localparam logic [7:0]  ADR_CLR  = 8'h08;
  localparam logic [7:0]  ADR_IEN  = 8'h0c;
  localparam logic [7:0]  ADR_BUZ  = 8'h10;
  localparam logic [7:0]  ADR_CD0  = 8'h20;
  localparam logic [7:0]  ADR_STEP = 8'h04;
  localparam logic [15:0] BUZ_HALF_RST = 16'h0001;
  typedef enum logic [1:0] {
    TTB_IDLE = 2'b00,
    TTB_RUN  = 2'b01
  } ttb_mode_type;
endpackage

// file: rtl/ttb_top.sv
// tick timer with countdowns and buzzer square wave, wishbone slave
// Summary of operation
// - the tick timer counts periods of a 1 kHz timebase made from clk_i.
// - a tick occurs every 100 ms and repeats while the timer runs.
// - the tick is the timer's terminal count, given as it reloads.
// - a 1 s countdown is loaded as 10 ticks.
// - each tick decrements every nonzero countdown; reaching zero fires it. A bus write to it in that cycle wins, yet a count of 1 still fires.
// - five countdowns: timeout, adc timeout, alarm off, sleep, blink.
// - the timer is started once by software and then runs free.
// - the timer's own reset is tied low so it never resets in operation.
// - the buzzer generator runs from a 6 kHz timebase made from clk_i.
// - the buzzer output is a 50% duty square wave.
// - the buzzer kill input is tied high so the output is never killed.
// - the buzzer generator's reset is tied low during operation.
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
module ttb_top #(
  parameter int DIV_1K = ttb_pkg::DIV_1K,
  parameter int DIV_6K = ttb_pkg::DIV_6K
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [31:0]             dat_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic                    we_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  output logic                         irq_o,
  output logic                         buzzer_o,
  output logic                         count_end_pulse_o,
  output logic      [ttb_pkg::NCD-1:0] cd_expire_o
);
  localparam int D1W = $clog2(DIV_1K);
  localparam int D6W = $clog2(DIV_6K);
  localparam int TW  = $clog2(ttb_pkg::TICK_KHZ);
  localparam int N   = ttb_pkg::NCD;
  localparam int CW  = ttb_pkg::CD_W;
  localparam int SW  = ttb_pkg::ST_W;

  typedef struct packed {
    logic                   ack;
    logic [31:0]            rdat;
    ttb_pkg::ttb_mode_type  mode;
    logic                   buz_en;
    logic [15:0]            buz_half;
    logic [15:0]            buz_cnt;
    logic                   buz;
    logic [D1W-1:0]         div1k;
    logic [D6W-1:0]         div6k;
    logic [TW-1:0]          tick_cnt;
    logic                   tc;
    logic [N-1:0]           exp;
    logic [N-1:0][CW-1:0]   cd;
    logic [SW-1:0]          stat;
    logic [SW-1:0]          ien;
    logic                   irq;
  } ttb_state_type;

  ttb_state_type r_reg;
  ttb_state_type r_next;

  // tie-offs on the internal timer and generator control inputs
  logic          tmr_rst;
  logic          buz_rst;
  logic          buz_kill_n;
  logic          khz;
  logic          six;
  logic          tick;
  logic          req;
  logic          wr;
  logic [31:0]   wm;
  logic [N-1:0]  cd_wr;
  logic [SW-1:0] ev;

  assign tmr_rst    = 1'b0;
  assign buz_rst    = 1'b0;
  assign buz_kill_n = 1'b1;

  function automatic logic [31:0] byte_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [31:0] m);
    return (o & ~m) | (d & m);
  endfunction

  function automatic logic [7:0] cd_adr(input int i);
    return 8'(ttb_pkg::ADR_CD0 + ttb_pkg::ADR_STEP * i);
  endfunction

  always_comb begin
    logic [31:0] tmp;
    tmp    = '0;
    r_next = r_reg;
    r_next.ack  = 1'b0;
    r_next.exp  = '0;
    cd_wr  = '0;
    req    = cyc_i && stb_i && !r_reg.ack;
    wr     = req && we_i;
    wm     = byte_mask(sel_i);

    // free-running timebases, both always clocked from clk_i
    khz = (r_reg.div1k == D1W'(DIV_1K - 1));
    r_next.div1k = khz ? '0 : D1W'(r_reg.div1k + 1'b1);
    six = (r_reg.div6k == D6W'(DIV_6K - 1));
    r_next.div6k = six ? '0 : D6W'(r_reg.div6k + 1'b1);

    // terminal count reloads the period counter
    tick = (r_reg.mode == ttb_pkg::TTB_RUN) && khz &&
           (r_reg.tick_cnt == TW'(ttb_pkg::TICK_KHZ - 1));
    if (tmr_rst || tick) begin
      r_next.tick_cnt = '0;
    end else if ((r_reg.mode == ttb_pkg::TTB_RUN) && khz) begin
      r_next.tick_cnt = TW'(r_reg.tick_cnt + 1'b1);
    end
    r_next.tc = tick;

    // half period counted in 6 kHz steps; toggling keeps duty at 50%
    if (buz_rst || !r_reg.buz_en) begin
      r_next.buz     = 1'b0;
      r_next.buz_cnt = '0;
    end else if (six) begin
      if (r_reg.buz_cnt + 16'h0001 >= r_reg.buz_half) begin
        r_next.buz     = !r_reg.buz;
        r_next.buz_cnt = '0;
      end else begin
        r_next.buz_cnt = r_reg.buz_cnt + 16'h0001;
      end
    end

    for (int i = 0; i < N; i++) begin
      if (tick && (r_reg.cd[i] != '0)) begin
        r_next.cd[i]  = r_reg.cd[i] - 1'b1;
        r_next.exp[i] = (r_reg.cd[i] == CW'(1));
      end
      // zero stays zero: no decrement below it
      cd_wr[i] = wr && (adr_i == cd_adr(i));
      if (cd_wr[i]) begin
        r_next.cd[i] = CW'(merge(32'(r_reg.cd[i]), dat_i, wm));
      end
    end

    ev = {r_next.exp, tick};
    if (wr && adr_i == ttb_pkg::ADR_CLR) begin
      // a new event in the clearing cycle survives
      r_next.stat = (r_reg.stat & ~SW'(dat_i & wm)) | ev;
    end else begin
      r_next.stat = r_reg.stat | ev;
    end

    if (req) begin
      r_next.ack = 1'b1;
      case (adr_i)
        ttb_pkg::ADR_CTRL: begin
          tmp[ttb_pkg::CTRL_RUN] = (r_reg.mode == ttb_pkg::TTB_RUN);
          tmp[ttb_pkg::CTRL_BUZ] = r_reg.buz_en;
        end
        ttb_pkg::ADR_STAT: tmp = 32'(r_reg.stat);
        ttb_pkg::ADR_IEN:  tmp = 32'(r_reg.ien);
        ttb_pkg::ADR_BUZ:  tmp = 32'(r_reg.buz_half);
        default: begin
          for (int i = 0; i < N; i++) begin
            if (adr_i == cd_adr(i)) begin
              tmp = 32'(r_reg.cd[i]);
            end
          end
        end
      endcase
      r_next.rdat = we_i ? '0 : tmp;
    end

    if (wr) begin
      case (adr_i)
        ttb_pkg::ADR_CTRL: begin
          // start is one-way: only reset stops the timer
          if (sel_i[0] && dat_i[ttb_pkg::CTRL_RUN]) begin
            r_next.mode = ttb_pkg::TTB_RUN;
          end
          if (sel_i[0]) begin
            r_next.buz_en = dat_i[ttb_pkg::CTRL_BUZ];
          end
        end
        ttb_pkg::ADR_IEN: r_next.ien = SW'(merge(32'(r_reg.ien), dat_i, wm));
        ttb_pkg::ADR_BUZ: begin
          r_next.buz_half = 16'(merge(32'(r_reg.buz_half), dat_i, wm));
        end
        default: ;
      endcase
    end
    r_next.irq = |(r_next.stat & r_next.ien);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg          <= '0;
      r_reg.mode     <= ttb_pkg::TTB_IDLE;
      r_reg.buz_half <= ttb_pkg::BUZ_HALF_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign dat_o             = r_reg.rdat;
  assign ack_o             = r_reg.ack;
  assign irq_o             = r_reg.irq;
  assign buzzer_o          = r_reg.buz && buz_kill_n;
  assign count_end_pulse_o = r_reg.tc;
  assign cd_expire_o       = r_reg.exp;

  // helper: khz steps seen since the last tick
  logic [TW:0] h_k_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      h_k_reg <= '0;
    end else if (khz && r_reg.mode == ttb_pkg::TTB_RUN) begin
      h_k_reg <= h_k_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_tick_period;
    tick |-> h_k_reg == (TW+1)'(ttb_pkg::TICK_KHZ - 1);
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick period wrong");

  property p_tc_pulse;
    tick |=> count_end_pulse_o ##1 !count_end_pulse_o;
  endproperty
  a_tc_pulse: assert property (p_tc_pulse)
    else $error("terminal count pulse wrong");

  property p_khz_wrap;
    khz |=> r_reg.div1k == '0;
  endproperty
  a_khz_wrap: assert property (p_khz_wrap)
    else $error("1 kHz timebase wrap wrong");

  property p_six_wrap;
    six |=> r_reg.div6k == '0;
  endproperty
  a_six_wrap: assert property (p_six_wrap)
    else $error("6 kHz timebase wrap wrong");

  property p_cd_dec;
    tick && r_reg.cd[0] > CW'(1) && !cd_wr[0]
      |=> r_reg.cd[0] == $past(r_reg.cd[0]) - 1'b1;
  endproperty
  a_cd_dec: assert property (p_cd_dec)
    else $error("countdown not decremented");

  property p_cd_fire;
    tick && r_reg.cd[ttb_pkg::CD_BLINK] == CW'(1)
      |=> cd_expire_o[ttb_pkg::CD_BLINK] ##1
          r_reg.stat[ttb_pkg::ST_CD0 + ttb_pkg::CD_BLINK];
  endproperty
  a_cd_fire: assert property (p_cd_fire)
    else $error("countdown expiry not signalled");

  property p_cd_hold;
    r_reg.cd[ttb_pkg::CD_SLEEP] == '0 && !cd_wr[ttb_pkg::CD_SLEEP]
      |=> r_reg.cd[ttb_pkg::CD_SLEEP] == '0;
  endproperty
  a_cd_hold: assert property (p_cd_hold)
    else $error("countdown left zero without reload");

  property p_run_sticky;
    r_reg.mode == ttb_pkg::TTB_RUN |=> r_reg.mode == ttb_pkg::TTB_RUN;
  endproperty
  a_run_sticky: assert property (p_run_sticky)
    else $error("timer stopped after start");

  property p_tmr_count;
    r_reg.mode == ttb_pkg::TTB_RUN && khz && !tick
      |=> r_reg.tick_cnt == $past(r_reg.tick_cnt) + 1'b1;
  endproperty
  a_tmr_count: assert property (p_tmr_count)
    else $error("timer count reset or stalled");

  property p_buz_toggle;
    r_reg.buz_en && six && r_reg.buz_cnt + 16'h0001 >= r_reg.buz_half
      |=> buzzer_o != $past(buzzer_o);
  endproperty
  a_buz_toggle: assert property (p_buz_toggle)
    else $error("buzzer did not toggle");

  property p_buz_steady;
    !six |=> buzzer_o == $past(buzzer_o) || !$past(r_reg.buz_en);
  endproperty
  a_buz_steady: assert property (p_buz_steady)
    else $error("buzzer changed between steps");

  property p_irq_level;
    irq_o == |(r_reg.stat & r_reg.ien);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level does not match status");

  property p_stat_sticky;
    r_reg.stat[ttb_pkg::ST_TICK] && !(wr && adr_i == ttb_pkg::ADR_CLR)
      |=> r_reg.stat[ttb_pkg::ST_TICK];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky)
    else $error("tick status lost without a clear");

  property p_khz_step;
    !khz |=> r_reg.div1k == D1W'($past(r_reg.div1k) + 1'b1);
  endproperty
  a_khz_step: assert property (p_khz_step)
    else $error("1 kHz timebase did not advance");

  property p_exp_zero;
    cd_expire_o[ttb_pkg::CD_TIMEOUT]
      |-> r_reg.cd[ttb_pkg::CD_TIMEOUT] == '0 ||
          $past(cd_wr[ttb_pkg::CD_TIMEOUT]);
  endproperty
  a_exp_zero: assert property (p_exp_zero)
    else $error("countdown expired while nonzero");

  property p_exp_once;
    |cd_expire_o |=> cd_expire_o == '0;
  endproperty
  a_exp_once: assert property (p_exp_once)
    else $error("countdown expiry longer than one cycle");

  // drive drops one clock cycle after disable, so no stale half wave
  property p_buz_off;
    !r_reg.buz_en |=> !buzzer_o;
  endproperty
  a_buz_off: assert property (p_buz_off)
    else $error("buzzer driven while disabled");

  c_tick: cover property (count_end_pulse_o);
  c_expire: cover property (|cd_expire_o ##1 irq_o);
  c_sec_load: cover property (cd_wr[ttb_pkg::CD_TIMEOUT] &&
                              dat_i == 32'(ttb_pkg::SEC_TICKS));
  c_buzz: cover property ($rose(buzzer_o));
  c_irq: cover property ($rose(irq_o));
endmodule

// file: dv/ttb_buzzer_model.sv
// buzzer model that measures the high and low spans of its drive
module ttb_buzzer_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wave_i,
  output logic      [15:0] hi_len_o,
  output logic      [15:0] lo_len_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        last_reg;
  logic [15:0] run_reg;
  // a span is kept only once the level changes, so partial runs never count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_reg <= 1'b0;
      run_reg  <= 16'h0001;
      hi_len_o <= 16'h0000;
      lo_len_o <= 16'h0000;
    end else if (wave_i !== last_reg) begin
      last_reg <= wave_i;
      run_reg  <= 16'h0001;
      if (last_reg) hi_len_o <= run_reg;
      else lo_len_o <= run_reg;
    end else begin
      run_reg <= run_reg + 16'h0001;
    end
  end
endmodule

// file: dv/test_ttb_top.sv
// self-checking bench for the tick timer and buzzer block
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module test_ttb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D1K = 10;
  localparam int D6K = 4;
  localparam int LOADS [5] = '{10, 1, 2, 3, 5};
  logic                    clk_i;
  logic                    rst_i;
  logic [7:0]              adr_i;
  logic [31:0]             dat_i;
  logic [3:0]              sel_i;
  logic                    we_i;
  logic                    cyc_i;
  logic                    stb_i;
  logic [31:0]             dat_o;
  logic                    ack_o;
  logic                    irq_o;
  logic                    buzzer_o;
  logic                    count_end_pulse_o;
  logic [ttb_pkg::NCD-1:0] cd_expire_o;
  logic [15:0]             hi_len;
  logic [15:0]             lo_len;
  logic [31:0]             rd;
  int                      n_errors;
  int                      checked;
  int                      n_ticks;
  int                      cyc_n;
  int                      tick_at;
  int                      period;
  int                      exp_at [5];
  int                      exp_n [5];

  ttb_top #(.DIV_1K(D1K), .DIV_6K(D6K)) i_dut (.clk_i(clk_i),
    .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .buzzer_o(buzzer_o),
    .count_end_pulse_o(count_end_pulse_o), .cd_expire_o(cd_expire_o));
  ttb_buzzer_model i_buz (.clk_i(clk_i), .rst_i(rst_i), .wave_i(buzzer_o),
    .hi_len_o(hi_len), .lo_len_o(lo_len));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // expiry is logged as the tick number on which it came
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (count_end_pulse_o === 1'b1) begin
      n_ticks <= n_ticks + 1;
      period  <= cyc_n - tick_at;
      tick_at <= cyc_n;
    end
    for (int i = 0; i < 5; i++)
      if (cd_expire_o[i] === 1'b1) begin
        exp_at[i] <= n_ticks + 1;
        exp_n[i]  <= exp_n[i] + 1;
      end
  end

  task automatic wb(input logic [7:0] a, input logic w, input int d);
    @(posedge clk_i);
    adr_i <= a;
    we_i  <= w;
    sel_i <= 4'hf;
    dat_i <= 32'(d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    // no answer latency assumed: the wait ends on ack_o, bounded only by the watchdog
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wait_ticks(input int k);
    int t;
    t = n_ticks + k;
    while (n_ticks < t) @(posedge clk_i);
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end

  initial begin
    {rst_i, adr_i, dat_i, sel_i, we_i, cyc_i, stb_i} = {1'b1, 47'h0};
    {n_errors, checked, n_ticks, cyc_n, tick_at, period} = '0;
    foreach (exp_n[i]) {exp_n[i], exp_at[i]} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(ttb_pkg::ADR_CTRL, 1'b0, 0);
    `CHK(rd, 32'h0)
    wb(ttb_pkg::ADR_BUZ, 1'b0, 0);
    `CHK(rd[15:0], ttb_pkg::BUZ_HALF_RST)
    wb(8'h40, 1'b1, -1);
    wb(8'h40, 1'b0, 0);
    `CHK(rd, 32'h0)
    // counts go in before the start so none sees a partial period
    for (int i = 0; i < 5; i++)
      wb(8'(ttb_pkg::ADR_CD0 + ttb_pkg::ADR_STEP * i), 1'b1, LOADS[i]);
    wb(ttb_pkg::ADR_CTRL, 1'b1, 1);
    wait_ticks(5);
    wb(ttb_pkg::ADR_CD0, 1'b0, 0);
    `CHK(rd[15:0], 16'h0005)
    wait_ticks(6);
    `CHK(period, 100 * D1K)
    for (int i = 0; i < 5; i++) begin
      wb(8'(ttb_pkg::ADR_CD0 + ttb_pkg::ADR_STEP * i), 1'b0, 0);
      `CHK(rd[15:0], 16'h0000)
      `CHK(exp_at[i], LOADS[i])
      `CHK(exp_n[i], 1)
    end
    wb(ttb_pkg::ADR_STAT, 1'b0, 0);
    `CHK(rd[5:0], 6'h3f)
    `CHK(irq_o, 1'b0)
    wb(ttb_pkg::ADR_IEN, 1'b1, 1);
    wb(ttb_pkg::ADR_CLR, 1'b1, 32'h3e);
    `CHK(irq_o, 1'b1)
    wb(ttb_pkg::ADR_CLR, 1'b1, 1);
    wb(ttb_pkg::ADR_STAT, 1'b0, 0);
    `CHK(rd[5:0], 6'h00)
    `CHK(irq_o, 1'b0)
    // the run bit is one-way, so writing zero must not stop the ticks
    wb(ttb_pkg::ADR_CTRL, 1'b1, 0);
    wb(ttb_pkg::ADR_CTRL, 1'b0, 0);
    `CHK(rd[0], 1'b1)
    wait_ticks(1);
    `CHK(n_ticks, 12)
    `CHK(buzzer_o, 1'b0)
    wb(ttb_pkg::ADR_BUZ, 1'b1, 3);
    wb(ttb_pkg::ADR_CTRL, 1'b1, 3);
    repeat (60) @(posedge clk_i);
    `CHK(hi_len, 16'(3 * D6K))
    `CHK(lo_len, 16'(3 * D6K))
    wb(ttb_pkg::ADR_BUZ, 1'b1, 0);
    repeat (30) @(posedge clk_i);
    `CHK(hi_len, 16'(D6K))
    `CHK(lo_len, 16'(D6K))
    wb(ttb_pkg::ADR_CTRL, 1'b1, 1);
    repeat (5) @(posedge clk_i);
    `CHK(buzzer_o, 1'b0)
    print_verdict();
  end
endmodule
